// ### core/psa_regs.vh
// Register offsets, field positions, widths and reset values of the program-flow block.
`ifndef PSA_REGS_VH
`define PSA_REGS_VH

// Widths of the program counter, jump target, high latch, data address and bus address.
`define PSA_PC_W            13
`define PSA_JUMP_W          11
`define PSA_LATCH_W         5
`define PSA_DADDR_W         9
`define PSA_AXI_ADDR_W      8

// Register byte offsets on the AXI4-Lite bus.
`define PSA_OFF_LOW_BYTE    8'h00
`define PSA_OFF_HIGH_LATCH  8'h04
`define PSA_OFF_FILE_SEL    8'h08
`define PSA_OFF_BANK_CTRL   8'h0C
`define PSA_OFF_DATA_ADDR   8'h10

// Register indices produced by the address decoder.
`define PSA_IDX_LOW_BYTE    3'h0
`define PSA_IDX_HIGH_LATCH  3'h1
`define PSA_IDX_FILE_SEL    3'h2
`define PSA_IDX_BANK_CTRL   3'h3
`define PSA_IDX_DATA_ADDR   3'h4
`define PSA_IDX_NONE        3'h7

// Field positions in the bank control register.
`define PSA_BANK_IND_BIT    7
`define PSA_BANK_DIR_HI     6
`define PSA_BANK_DIR_LO     5

// Reset values.
`define PSA_PC_RESET        13'h0000
`define PSA_LATCH_RESET     5'h00
`define PSA_FSP_RESET       8'h00
`define PSA_BANK_RESET      3'h0

// Interrupt vector address and the file address of the indirect data port.
`define PSA_INT_VECTOR      13'h0004
`define PSA_INDIRECT_PORT   7'h00

// AXI response codes.
`define PSA_RESP_OKAY       2'h0
`define PSA_RESP_SLVERR     2'h2

`endif

// ### core/psa_ret_stack.v
// Circular hardware return stack with a hidden pointer.
`timescale 1ns/1ns
module psa_ret_stack #(
  parameter DEPTH = 8,
  parameter WIDTH = 13,
  parameter PTR_W = 3
) (
  input  wire             aclk,
  input  wire             aresetn,
  input  wire             push,
  input  wire             pop,
  input  wire [WIDTH-1:0] push_data,
  output wire [WIDTH-1:0] top_data
);

  reg  [PTR_W-1:0] ptr_reg;
  reg  [WIDTH-1:0] entry_reg [0:DEPTH-1];
  wire [PTR_W-1:0] ptr_prev;

  // The pointer only wraps, so no overflow or underflow is ever flagged.
  assign ptr_prev = ptr_reg - {{(PTR_W-1){1'b0}}, 1'b1};
  assign top_data = entry_reg[ptr_prev];

  // The pointer has no port of its own and cannot be seen or changed from outside.
  always @(posedge aclk) begin
    if (!aresetn) begin
      ptr_reg <= {PTR_W{1'b0}};
    end else if (push) begin
      ptr_reg <= ptr_reg + {{(PTR_W-1){1'b0}}, 1'b1};
    end else if (pop) begin
      ptr_reg <= ptr_prev;
    end
  end

  // Each entry is written when the pointer names it; the ninth push reuses entry zero.
  genvar i;
  generate
    for (i = 0; i < DEPTH; i = i + 1) begin : g_entry
      always @(posedge aclk) begin
        if (!aresetn) begin
          entry_reg[i] <= {WIDTH{1'b0}};
        end else if (push && (ptr_reg == i)) begin
          entry_reg[i] <= push_data;
        end
      end
    end
  endgenerate

endmodule

// ### core/psa_core.v
// Program counter, return stack and data address formation behind an AXI4-Lite slave.
`timescale 1ns/1ns
`include "psa_regs.vh"
module psa_core #(
  parameter STACK_DEPTH = 8,
  parameter STACK_PTR_W = 3
) (
  input  wire                       aclk,
  input  wire                       aresetn,
  // AXI4-Lite write address channel.
  input  wire [`PSA_AXI_ADDR_W-1:0] s_axi_awaddr,
  input  wire                       s_axi_awvalid,
  output wire                       s_axi_awready,
  // AXI4-Lite write data channel.
  input  wire [31:0]                s_axi_wdata,
  input  wire [3:0]                 s_axi_wstrb,
  input  wire                       s_axi_wvalid,
  output wire                       s_axi_wready,
  // AXI4-Lite write response channel.
  output wire [1:0]                 s_axi_bresp,
  output wire                       s_axi_bvalid,
  input  wire                       s_axi_bready,
  // AXI4-Lite read address channel.
  input  wire [`PSA_AXI_ADDR_W-1:0] s_axi_araddr,
  input  wire                       s_axi_arvalid,
  output wire                       s_axi_arready,
  // AXI4-Lite read data channel.
  output wire [31:0]                s_axi_rdata,
  output wire [1:0]                 s_axi_rresp,
  output wire                       s_axi_rvalid,
  input  wire                       s_axi_rready,
  // Program flow requests from the decoder and interrupt logic.
  input  wire                       pc_advance,
  input  wire                       op_call,
  input  wire                       op_direct_jump,
  input  wire [`PSA_JUMP_W-1:0]     op_target,
  input  wire                       op_return,
  input  wire                       op_return_with_literal,
  input  wire                       op_return_from_interrupt,
  input  wire                       int_vector_req,
  input  wire                       low_byte_wr_en,
  input  wire [7:0]                 low_byte_wr_data,
  // Program memory fetch address.
  output wire [`PSA_PC_W-1:0]       fetch_addr,
  // Data access requests from the decoder.
  input  wire                       acc_valid,
  input  wire                       acc_write,
  input  wire [6:0]                 acc_file_addr,
  input  wire [7:0]                 acc_wr_data,
  output wire [7:0]                 acc_rd_data,
  output wire                       acc_rd_valid,
  // Data memory bus.
  output wire [`PSA_DADDR_W-1:0]    dmem_addr,
  output wire                       dmem_rd_en,
  output wire                       dmem_wr_en,
  output wire [7:0]                 dmem_wr_data,
  input  wire [7:0]                 dmem_rd_data
);

  // Program counter state and the latch for its upper part.
  reg  [`PSA_PC_W-1:0]       pc_reg;
  reg  [`PSA_PC_W-1:0]       pc_next;
  reg  [`PSA_LATCH_W-1:0]    pc_high_latch_reg;
  reg                        stack_push;
  reg                        stack_pop;
  wire [`PSA_PC_W-1:0]       stack_top;
  wire                       any_return;

  // Addressing state.
  reg  [7:0]                 file_select_pointer_reg;
  reg                        indirect_bank_bit_reg;
  reg  [1:0]                 direct_bank_bits_reg;
  reg  [`PSA_DADDR_W-1:0]    dmem_addr_reg;
  reg                        dmem_rd_en_reg;
  reg                        dmem_wr_en_reg;
  reg  [7:0]                 dmem_wr_data_reg;
  reg                        acc_null_reg;
  reg  [7:0]                 acc_rd_data_reg;
  reg                        acc_rd_valid_reg;
  wire                       acc_is_indirect;
  wire                       acc_self_point;
  wire [`PSA_DADDR_W-1:0]    acc_addr;

  // Bus slave state.
  reg                        aw_held_reg;
  reg  [`PSA_AXI_ADDR_W-1:0] aw_addr_reg;
  reg                        w_held_reg;
  reg  [7:0]                 w_data_reg;
  reg                        w_lane0_reg;
  reg                        bvalid_reg;
  reg  [1:0]                 bresp_reg;
  reg                        rvalid_reg;
  reg  [31:0]                rdata_reg;
  reg  [1:0]                 rresp_reg;
  wire                       aw_take;
  wire                       w_take;
  wire                       have_aw;
  wire                       have_w;
  wire [`PSA_AXI_ADDR_W-1:0] cur_awaddr;
  wire [7:0]                 cur_wdata;
  wire                       cur_lane0;
  wire                       wr_fire;
  wire                       wr_en;
  wire [2:0]                 wr_idx;
  wire [2:0]                 rd_idx;
  wire                       ar_take;
  wire                       bus_low_wr;
  reg  [31:0]                rd_value;

  // Maps a byte address to a register index; unaligned or unknown gives none.
  function [2:0] psa_index;
    input [`PSA_AXI_ADDR_W-1:0] addr;
    begin
      case (addr)
        `PSA_OFF_LOW_BYTE:   psa_index = `PSA_IDX_LOW_BYTE;
        `PSA_OFF_HIGH_LATCH: psa_index = `PSA_IDX_HIGH_LATCH;
        `PSA_OFF_FILE_SEL:   psa_index = `PSA_IDX_FILE_SEL;
        `PSA_OFF_BANK_CTRL:  psa_index = `PSA_IDX_BANK_CTRL;
        `PSA_OFF_DATA_ADDR:  psa_index = `PSA_IDX_DATA_ADDR;
        default:             psa_index = `PSA_IDX_NONE;
      endcase
    end
  endfunction

  // Write channels are taken independently and held until both are present.
  assign s_axi_awready = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready  = !w_held_reg && !bvalid_reg;
  assign aw_take       = s_axi_awvalid && s_axi_awready;
  assign w_take        = s_axi_wvalid && s_axi_wready;
  assign have_aw       = aw_held_reg || aw_take;
  assign have_w        = w_held_reg || w_take;
  assign cur_awaddr    = aw_held_reg ? aw_addr_reg : s_axi_awaddr;
  assign cur_wdata     = w_held_reg ? w_data_reg : s_axi_wdata[7:0];
  assign cur_lane0     = w_held_reg ? w_lane0_reg : s_axi_wstrb[0];
  assign wr_fire       = have_aw && have_w && !bvalid_reg;
  assign wr_idx        = psa_index(cur_awaddr);
  assign wr_en         = wr_fire && cur_lane0;
  assign bus_low_wr    = wr_en && (wr_idx == `PSA_IDX_LOW_BYTE);
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;

  // Holds a channel taken early, then issues the response once both have arrived.
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= {`PSA_AXI_ADDR_W{1'b0}};
      w_held_reg  <= 1'b0;
      w_data_reg  <= 8'h00;
      w_lane0_reg <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `PSA_RESP_OKAY;
    end else if (wr_fire) begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      bvalid_reg  <= 1'b1;
      bresp_reg   <= (wr_idx == `PSA_IDX_NONE) ? `PSA_RESP_SLVERR : `PSA_RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (w_take) begin
        w_held_reg  <= 1'b1;
        w_data_reg  <= s_axi_wdata[7:0];
        w_lane0_reg <= s_axi_wstrb[0];
      end
      if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // Software-visible control registers; only lane zero carries data.
  always @(posedge aclk) begin
    if (!aresetn) begin
      pc_high_latch_reg       <= `PSA_LATCH_RESET;
      file_select_pointer_reg <= `PSA_FSP_RESET;
      indirect_bank_bit_reg   <= 1'b0;
      direct_bank_bits_reg    <= 2'h0;
    end else if (wr_en) begin
      case (wr_idx)
        `PSA_IDX_HIGH_LATCH: begin
          pc_high_latch_reg <= cur_wdata[`PSA_LATCH_W-1:0];
        end
        `PSA_IDX_FILE_SEL: begin
          file_select_pointer_reg <= cur_wdata;
        end
        `PSA_IDX_BANK_CTRL: begin
          indirect_bank_bit_reg <= cur_wdata[`PSA_BANK_IND_BIT];
          direct_bank_bits_reg  <= cur_wdata[`PSA_BANK_DIR_HI:`PSA_BANK_DIR_LO];
        end
        default: begin
          pc_high_latch_reg <= pc_high_latch_reg;
        end
      endcase
    end
  end

  // Read path answers one cycle after the address is taken.
  assign s_axi_arready = !rvalid_reg;
  assign ar_take       = s_axi_arvalid && s_axi_arready;
  assign rd_idx        = psa_index(s_axi_araddr);
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;

  // Read value selection; the upper counter bits and stack pointer have no entry.
  always @* begin
    rd_value = 32'h00000000;
    case (rd_idx)
      `PSA_IDX_LOW_BYTE:   rd_value[7:0] = pc_reg[7:0];
      `PSA_IDX_HIGH_LATCH: rd_value[`PSA_LATCH_W-1:0] = pc_high_latch_reg;
      `PSA_IDX_FILE_SEL:   rd_value[7:0] = file_select_pointer_reg;
      `PSA_IDX_BANK_CTRL: begin
        rd_value[`PSA_BANK_IND_BIT] = indirect_bank_bit_reg;
        rd_value[`PSA_BANK_DIR_HI:`PSA_BANK_DIR_LO] = direct_bank_bits_reg;
      end
      `PSA_IDX_DATA_ADDR:  rd_value[`PSA_DADDR_W-1:0] = dmem_addr_reg;
      default:             rd_value = 32'h00000000;
    endcase
  end

  // Read data register, held until the master accepts it.
  always @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h00000000;
      rresp_reg  <= `PSA_RESP_OKAY;
    end else if (ar_take) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= rd_value;
      rresp_reg  <= (rd_idx == `PSA_IDX_NONE) ? `PSA_RESP_SLVERR : `PSA_RESP_OKAY;
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // The three return kinds all restore the counter from the stack.
  assign any_return = op_return || op_return_with_literal || op_return_from_interrupt;

  // Next counter value; flow changes outrank low-byte writes, which outrank advance.
  always @* begin
    pc_next    = pc_reg;
    stack_push = 1'b0;
    stack_pop  = 1'b0;
    if (int_vector_req) begin
      pc_next    = `PSA_INT_VECTOR;
      stack_push = 1'b1;
    end else if (op_call) begin
      pc_next    = {pc_high_latch_reg[4:3], op_target};
      stack_push = 1'b1;
    end else if (op_direct_jump) begin
      pc_next    = {pc_high_latch_reg[4:3], op_target};
    end else if (any_return) begin
      pc_next    = stack_top;
      stack_pop  = 1'b1;
    end else if (low_byte_wr_en) begin
      pc_next    = {pc_high_latch_reg[4:0], low_byte_wr_data};
    end else if (bus_low_wr) begin
      pc_next    = {pc_high_latch_reg[4:0], cur_wdata};
    end else if (pc_advance) begin
      pc_next    = pc_reg + 13'h0001;
    end
  end

  // Program counter register, cleared by any reset.
  always @(posedge aclk) begin
    if (!aresetn) begin
      pc_reg <= `PSA_PC_RESET;
    end else begin
      pc_reg <= pc_next;
    end
  end

  assign fetch_addr = pc_reg;

  // The stack sees only the counter; the latch is never pushed or popped.
  psa_ret_stack #(
    .DEPTH     (STACK_DEPTH),
    .WIDTH     (`PSA_PC_W),
    .PTR_W     (STACK_PTR_W)
  ) u_stack (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .push      (stack_push),
    .pop       (stack_pop),
    .push_data (pc_reg),
    .top_data  (stack_top)
  );

  // Operand zero names the indirect port, which redirects through the pointer.
  assign acc_is_indirect = (acc_file_addr == `PSA_INDIRECT_PORT);
  // The pointer names the indirect port itself in any bank when its low seven bits are zero.
  assign acc_self_point  = acc_is_indirect &&
                           (file_select_pointer_reg[6:0] == `PSA_INDIRECT_PORT);
  // Indirect uses bank bit and pointer, direct uses bank bits and operand.
  assign acc_addr = acc_is_indirect ?
                    {indirect_bank_bit_reg, file_select_pointer_reg} :
                    {direct_bank_bits_reg, acc_file_addr};

  // Data memory request stage; a self-pointing access reaches no memory.
  always @(posedge aclk) begin
    if (!aresetn) begin
      dmem_addr_reg    <= {`PSA_DADDR_W{1'b0}};
      dmem_rd_en_reg   <= 1'b0;
      dmem_wr_en_reg   <= 1'b0;
      dmem_wr_data_reg <= 8'h00;
      acc_null_reg     <= 1'b0;
    end else begin
      dmem_rd_en_reg   <= acc_valid && !acc_write && !acc_self_point;
      dmem_wr_en_reg   <= acc_valid && acc_write && !acc_self_point;
      acc_null_reg     <= acc_valid && !acc_write && acc_self_point;
      if (acc_valid) begin
        dmem_addr_reg    <= acc_addr;
        dmem_wr_data_reg <= acc_wr_data;
      end
    end
  end

  // Read result stage; a self-pointing read returns zero instead of memory data.
  always @(posedge aclk) begin
    if (!aresetn) begin
      acc_rd_data_reg  <= 8'h00;
      acc_rd_valid_reg <= 1'b0;
    end else begin
      acc_rd_valid_reg <= dmem_rd_en_reg || acc_null_reg;
      if (acc_null_reg) begin
        acc_rd_data_reg <= 8'h00;
      end else if (dmem_rd_en_reg) begin
        acc_rd_data_reg <= dmem_rd_data;
      end
    end
  end

  assign dmem_addr    = dmem_addr_reg;
  assign dmem_rd_en   = dmem_rd_en_reg;
  assign dmem_wr_en   = dmem_wr_en_reg;
  assign dmem_wr_data = dmem_wr_data_reg;
  assign acc_rd_data  = acc_rd_data_reg;
  assign acc_rd_valid = acc_rd_valid_reg;

endmodule

// ### tb/psa_core_props.sv
// Concurrent checks on the ports of the program-flow block.
`timescale 1ns/1ns
`include "psa_regs.vh"
module psa_core_props (
  input logic        aclk,
  input logic        aresetn,
  input logic        s_axi_awvalid,
  input logic        s_axi_wvalid,
  input logic        pc_advance,
  input logic        op_call,
  input logic        op_direct_jump,
  input logic [10:0] op_target,
  input logic        op_return,
  input logic        op_return_with_literal,
  input logic        op_return_from_interrupt,
  input logic        int_vector_req,
  input logic        low_byte_wr_en,
  input logic [7:0]  low_byte_wr_data,
  input logic [12:0] fetch_addr,
  input logic        acc_valid,
  input logic        acc_write,
  input logic [6:0]  acc_file_addr,
  input logic [7:0]  acc_wr_data,
  input logic [7:0]  acc_rd_data,
  input logic        acc_rd_valid,
  input logic [8:0]  dmem_addr,
  input logic        dmem_rd_en,
  input logic        dmem_wr_en,
  input logic [7:0]  dmem_wr_data,
  input logic [7:0]  dmem_rd_data
);
  // Request groups; idle means nothing may move the counter but an advance.
  wire any_ret = op_return | op_return_with_literal | op_return_from_interrupt;
  wire hi_req  = int_vector_req | op_call | op_direct_jump | any_ret;
  wire idle    = !hi_req && !low_byte_wr_en && !s_axi_awvalid && !s_axi_wvalid;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_call_then_ret;
    op_call && !int_vector_req ##1 !hi_req
      ##1 any_ret && !int_vector_req && !op_call && !op_direct_jump;
  endsequence
  sequence s_read_req;
    acc_valid && !acc_write;
  endsequence
  property p_reset_clear; $rose(aresetn) |-> fetch_addr == `PSA_PC_RESET; endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("pc not clear");
  property p_vector; int_vector_req |=> fetch_addr == `PSA_INT_VECTOR; endproperty
  a_vector: assert property (p_vector) else $error("vector not taken");
  property p_call; op_call && !int_vector_req |=> fetch_addr[10:0] == $past(op_target);
  endproperty
  a_call: assert property (p_call) else $error("call target wrong");
  property p_jump;
    op_direct_jump && !op_call && !int_vector_req |=> fetch_addr[10:0] == $past(op_target);
  endproperty
  a_jump: assert property (p_jump) else $error("jump target wrong");
  property p_ret; s_call_then_ret |=> fetch_addr == $past(fetch_addr, 3); endproperty
  a_ret: assert property (p_ret) else $error("return address wrong");
  property p_low_byte;
    low_byte_wr_en && !hi_req |=> fetch_addr[7:0] == $past(low_byte_wr_data);
  endproperty
  a_low_byte: assert property (p_low_byte) else $error("low byte not loaded");
  property p_advance; idle && pc_advance |=> fetch_addr == $past(fetch_addr) + 13'h1;
  endproperty
  a_advance: assert property (p_advance) else $error("advance wrong");
  property p_hold; idle && !pc_advance |=> $stable(fetch_addr); endproperty
  a_hold: assert property (p_hold) else $error("pc moved unasked");
  property p_direct;
    acc_valid && acc_file_addr != 7'h00 |=> dmem_addr[6:0] == $past(acc_file_addr);
  endproperty
  a_direct: assert property (p_direct) else $error("direct address wrong");
  property p_write;
    acc_valid && acc_write && acc_file_addr != 7'h00
      |=> dmem_wr_en && !dmem_rd_en && dmem_wr_data == $past(acc_wr_data);
  endproperty
  a_write: assert property (p_write) else $error("write not issued");
  property p_rd_lat; s_read_req |-> ##2 acc_rd_valid; endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
  property p_rd_data; dmem_rd_en |=> acc_rd_valid && acc_rd_data == $past(dmem_rd_data);
  endproperty
  a_rd_data: assert property (p_rd_data) else $error("read data wrong");
endmodule

bind psa_core psa_core_props u_psa_core_props (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_wvalid, .pc_advance, .op_call, .op_direct_jump,
  .op_target, .op_return, .op_return_with_literal, .op_return_from_interrupt,
  .int_vector_req, .low_byte_wr_en, .low_byte_wr_data, .fetch_addr, .acc_valid,
  .acc_write, .acc_file_addr, .acc_wr_data, .acc_rd_data, .acc_rd_valid, .dmem_addr,
  .dmem_rd_en, .dmem_wr_en, .dmem_wr_data, .dmem_rd_data
);

// ### tb/psa_dmem_model.sv
// Data memory model that answers reads in the cycle of the read strobe.
`timescale 1ns/1ns
module psa_dmem_model (
  input  wire logic       aclk,
  input  wire logic [8:0] addr,
  input  wire logic       rd_en,
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_data,
  output wire       [7:0] rd_data
);
  logic [7:0] mem [0:511];
  logic [7:0] last;
  // Cells start with a pattern no scenario writes, so a zero read stands out.
  initial begin
    for (int i = 0; i < 512; i++) mem[i] = 8'h5C;
    last = 8'h00;
  end
  // Outside a read the bus shows the inverse of the last value read.
  assign rd_data = rd_en ? mem[addr] : ~last;
  // Writes land at the edge that samples the write strobe.
  always @(posedge aclk) begin
    if (wr_en) begin
      mem[addr] <= wr_data;
    end
    if (rd_en) begin
      last <= mem[addr];
    end
  end
endmodule

// ### tb/psa_core_tb_top.sv
// Self-checking bench for the program-flow block with a data memory model.
`timescale 1ns/1ns
`include "psa_regs.vh"
module psa_core_tb_top;
  localparam [6:0] INT = 7'h40, CALL = 7'h20, JMP = 7'h10, LBW = 7'h01;
  localparam [6:0] RET = 7'h08, RETL = 7'h04, RETI = 7'h02;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready, pc_advance, acc_valid, acc_write;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, low_byte_wr_data, acc_wr_data;
  logic [31:0] s_axi_wdata, rv;
  logic [6:0]  rq, acc_file_addr;
  logic [10:0] op_target;
  logic [1:0]  rs;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  wire  [12:0] fetch_addr;
  wire  [7:0]  acc_rd_data, dmem_wr_data, dmem_rd_data;
  wire         acc_rd_valid, dmem_rd_en, dmem_wr_en;
  wire  [8:0]  dmem_addr;
  int          mismatches, num_checks;

  psa_core u_psa_core (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pc_advance, .op_call(rq[5]),
    .op_direct_jump(rq[4]), .op_target, .op_return(rq[3]), .op_return_with_literal(rq[2]),
    .op_return_from_interrupt(rq[1]), .int_vector_req(rq[6]), .low_byte_wr_en(rq[0]),
    .low_byte_wr_data, .fetch_addr, .acc_valid, .acc_write, .acc_file_addr, .acc_wr_data,
    .acc_rd_data, .acc_rd_valid, .dmem_addr, .dmem_rd_en, .dmem_wr_en, .dmem_wr_data,
    .dmem_rd_data
  );
  psa_dmem_model u_psa_dmem_model (
    .aclk, .addr(dmem_addr), .rd_en(dmem_rd_en), .wr_en(dmem_wr_en),
    .wr_data(dmem_wr_data), .rd_data(dmem_rd_data)
  );

  // Free-running 50 MHz clock.
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  task end_of_test;
    if (mismatches == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task hang;
    mismatches++;
    $display("[ERR] %0t bus answer missing", $time);
    end_of_test;
  endtask
  // Write: both channels offered together, each released once taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ad = 1'b0, dd = 1'b0, bd = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    for (int n = 0; n < 40 && !bd; n++) begin
      @(negedge aclk);
      ad |= s_axi_awready;
      dd |= s_axi_wready;
      bd = s_axi_bvalid;
      rs = s_axi_bresp;
      @(posedge aclk);
      if (ad) s_axi_awvalid <= 1'b0;
      if (dd) s_axi_wvalid <= 1'b0;
      if (bd) s_axi_bready <= 1'b0;
    end
    if (!bd) hang;
    chk(rs, er);
  endtask
  // Read: address held until taken, rready held until the data is seen.
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ad = 1'b0, dd = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    for (int n = 0; n < 40 && !dd; n++) begin
      @(negedge aclk);
      ad |= s_axi_arready;
      dd = s_axi_rvalid;
      rv = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge aclk);
      if (ad) s_axi_arvalid <= 1'b0;
      if (dd) s_axi_rready <= 1'b0;
    end
    if (!dd) hang;
    chk(rv, ed);
    chk(rs, er);
  endtask
  // One-cycle flow request, then the new counter value is judged.
  task fl(input logic [6:0] r, input logic [10:0] t, input logic [12:0] ep);
    @(posedge aclk);
    rq <= r;
    op_target <= t;
    low_byte_wr_data <= t[7:0];
    @(posedge aclk);
    rq <= 7'h00;
    @(negedge aclk);
    chk(fetch_addr, ep);
  endtask
  // One data access; strobes judged one cycle later, read data two cycles later.
  task ac(input logic w, input logic [6:0] fa, input logic [7:0] d,
          input logic [8:0] ea, input logic [1:0] en, input logic [7:0] ed);
    @(posedge aclk);
    acc_valid <= 1'b1;
    acc_write <= w;
    acc_file_addr <= fa;
    acc_wr_data <= d;
    @(posedge aclk);
    acc_valid <= 1'b0;
    @(negedge aclk);
    chk({dmem_rd_en, dmem_wr_en}, en);
    if (en != 2'b00) chk(dmem_addr, ea);
    if (en == 2'b01) chk(dmem_wr_data, d);
    @(negedge aclk);
    if (!w) chk({acc_rd_valid, acc_rd_data}, {1'b1, ed});
  endtask
  task adv(input int n, input logic [12:0] ep);
    @(posedge aclk);
    pc_advance <= 1'b1;
    repeat (n) @(posedge aclk);
    pc_advance <= 1'b0;
    @(negedge aclk);
    chk(fetch_addr, ep);
  endtask

  task t_reset;
    for (int i = 0; i < 5; i++) rd(8'(i * 4), 32'h0, `PSA_RESP_OKAY);
    rd(8'h14, 32'h0, `PSA_RESP_SLVERR);
    wr(8'h14, 32'h1, `PSA_RESP_SLVERR);
    chk(fetch_addr, 13'h0000);
  endtask
  task t_low;
    wr(`PSA_OFF_HIGH_LATCH, 32'hFFFF_FF0A, `PSA_RESP_OKAY);
    wr(`PSA_OFF_LOW_BYTE, 32'h0000_00A5, `PSA_RESP_OKAY);
    chk(fetch_addr, 13'h0AA5);
    rd(`PSA_OFF_LOW_BYTE, 32'hA5, `PSA_RESP_OKAY);
    rd(`PSA_OFF_HIGH_LATCH, 32'h0A, `PSA_RESP_OKAY);
    wr(`PSA_OFF_HIGH_LATCH, 32'h15, `PSA_RESP_OKAY);
    fl(LBW, 11'h0C3, 13'h15C3);
    adv(3, 13'h15C6);
    wr(`PSA_OFF_HIGH_LATCH, 32'h1F, `PSA_RESP_OKAY);
    fl(LBW, 11'h0FF, 13'h1FFF);
    adv(1, 13'h0000);
  endtask
  task automatic t_flow;
    logic [6:0] kinds [3];
    kinds = '{RET, RETL, RETI};
    wr(`PSA_OFF_HIGH_LATCH, 32'h18, `PSA_RESP_OKAY);
    fl(JMP, 11'h123, 13'h1923);
    for (int k = 0; k < 3; k++) begin
      fl(CALL, 11'h456, 13'h1C56);
      fl(kinds[k], 11'h000, 13'h1923);
    end
    fl(INT | CALL, 11'h456, `PSA_INT_VECTOR);
    fl(RETI, 11'h000, 13'h1923);
    rd(`PSA_OFF_HIGH_LATCH, 32'h18, `PSA_RESP_OKAY);
  endtask
  task t_circ;
    wr(`PSA_OFF_HIGH_LATCH, 32'h0, `PSA_RESP_OKAY);
    fl(JMP, 11'h000, 13'h0000);
    for (int i = 0; i < 10; i++) fl(CALL, 11'(256 + i), 13'(256 + i));
    for (int j = 1; j < 9; j++) fl(RET, 11'h000, 13'(265 - j));
    fl(RET, 11'h000, 13'h0108);
  endtask
  task t_data;
    wr(`PSA_OFF_FILE_SEL, 32'h25, `PSA_RESP_OKAY);
    wr(`PSA_OFF_BANK_CTRL, 32'h80, `PSA_RESP_OKAY);
    ac(1'b1, 7'h00, 8'h5A, 9'h125, 2'b01, 8'h00);
    ac(1'b0, 7'h00, 8'h00, 9'h125, 2'b10, 8'h5A);
    rd(`PSA_OFF_DATA_ADDR, 32'h125, `PSA_RESP_OKAY);
    wr(`PSA_OFF_DATA_ADDR, 32'h0, `PSA_RESP_OKAY);
    rd(`PSA_OFF_DATA_ADDR, 32'h125, `PSA_RESP_OKAY);
    wr(`PSA_OFF_BANK_CTRL, 32'h00, `PSA_RESP_OKAY);
    ac(1'b0, 7'h00, 8'h00, 9'h025, 2'b10, 8'h5C);
    for (int b = 0; b < 4; b++) begin
      wr(`PSA_OFF_BANK_CTRL, 32'(b * 32), `PSA_RESP_OKAY);
      ac(1'b1, 7'h7F, 8'(16 + b), 9'(b * 128 + 127), 2'b01, 8'h00);
    end
    for (int b = 0; b < 4; b++) begin
      wr(`PSA_OFF_BANK_CTRL, 32'(b * 32), `PSA_RESP_OKAY);
      ac(1'b0, 7'h7F, 8'h00, 9'(b * 128 + 127), 2'b10, 8'(16 + b));
    end
    wr(`PSA_OFF_FILE_SEL, 32'h00, `PSA_RESP_OKAY);
    ac(1'b1, 7'h00, 8'hEE, 9'h000, 2'b00, 8'h00);
    ac(1'b0, 7'h00, 8'h00, 9'h000, 2'b00, 8'h00);
  endtask

  // Quiet inputs, reset for five cycles, then every scenario in turn.
  initial begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    {rq, op_target, low_byte_wr_data, pc_advance} = 27'h0;
    {acc_valid, acc_write, acc_file_addr, acc_wr_data} = 17'h0;
    mismatches = 0;
    num_checks = 0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset;
    t_low;
    t_flow;
    t_circ;
    t_data;
    end_of_test;
  end
endmodule
